// File: rtl/pcpl_loader.sv
/*
 * Parallel configuration port loader: deserialises the host bus into
 * 32-bit packets, gathers four into a payload, and issues them in
 * execution order (slot 0 first) through a two-entry buffer.
 * Assumes the host clock is mclk_in, inputs synchronous to it, and the
 * downstream command/memory logic signals ready on the exec port.
 */
// What this block does
// - 128-bit memory word from four 32-bit packets
// - MSB first within bytes and packets
// - Execute per packet; data register takes 128
// - Host sends slot 3 first; execute slot 0 first
// - x32 mode: one packet per clock
// - First payload executes sync, ids, then no-op
// - Write/read last slot; data follows immediately
// - Frame data accepted every clock after write
// - Select change mid-request discards that request
// - x16 mode: two clocks, upper half first
// - x8 mode: four clocks, MSB byte first
// - x1 mode: one bit per clock, MSB first
// - 512-bit preamble precedes command stream
// - Trailing no-ops leave done and user flags alone
`include "pcpl_defs.svh"

module pcpl_loader (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic [1:0] width_mode_in,
	input wire logic mem_cleared_in,
	input wire logic host_port_select_n_in,
	input wire logic [`PCPL_BUS_W-1:0] host_config_data_bus_in,
	input wire logic exec_ready_in,
	input wire logic user_entered_in,
	output logic exec_valid_out,
	output pcpl_pkg::pcpl_exec_t exec_out,
	output logic payload_valid_out,
	output pcpl_pkg::pcpl_payload_t payload_out,
	output logic host_stall_out,
	output logic discard_out,
	output logic config_ready_flag_out,
	output logic config_complete_flag_out,
	output logic user_mode_flag_out
);

	// Registers
	logic [`PCPL_PKT_W-1:0] shift_reg, shift_next;
	logic [5:0] beat_reg, beat_next;
	logic [1:0] slot_reg;
	logic [`PCPL_PAY_W-1:0] gather_reg;
	logic sel_prev_reg;
	logic drop_reg;
	logic [2:0] pre_cnt_reg;
	logic data_mode_reg;
	logic data_pending_reg;
	pcpl_pkg::pcpl_state_t state_reg, state_next;
	logic [1:0] issue_reg;
	logic issuing_reg;
	logic [`PCPL_PAY_W-1:0] hold_reg;
	logic hold_data_reg;
	logic done_reg;
	logic user_reg;
	logic exec_valid_reg;
	logic payload_valid_reg;
	logic discard_reg;
	logic stall_reg;

	// Two-entry buffer between issue logic and consumer
	pcpl_pkg::pcpl_exec_t buf_mem [0:1];
	logic buf_wp_reg, buf_rp_reg;
	logic [1:0] buf_cnt_reg;

	// Beat decode for the selected width
	wire logic [5:0] beats_per_pkt;
	wire logic beat_fire;
	wire logic pkt_done;
	wire logic sel_active;
	wire logic sel_edge;
	wire logic [`PCPL_PKT_W-1:0] bus;
	assign bus = host_config_data_bus_in;
	assign beats_per_pkt =
		(width_mode_in == `PCPL_MODE_X1) ? `PCPL_BEATS_X1 :
		(width_mode_in == `PCPL_MODE_X8) ? `PCPL_BEATS_X8 :
		(width_mode_in == `PCPL_MODE_X16) ? `PCPL_BEATS_X16 :
		`PCPL_BEATS_X32;
	assign sel_active = !host_port_select_n_in;
	assign sel_edge = sel_active != sel_prev_reg;
	assign beat_fire = sel_active && !stall_reg;
	assign pkt_done = beat_fire && (beat_reg == beats_per_pkt - 6'h01);

	// Incoming beat shifts in from the low end so earliest is MSB
	always_comb begin
		case (width_mode_in)
		`PCPL_MODE_X1: shift_next = {shift_reg[30:0], bus[0]};
		`PCPL_MODE_X8: shift_next = {shift_reg[23:0], bus[7:0]};
		`PCPL_MODE_X16: shift_next = {shift_reg[15:0], bus[15:0]};
		default: shift_next = bus;
		endcase
	end
	assign beat_next = pkt_done ? 6'h00 : beat_reg + 6'h01;

	// Completed packet and payload
	wire logic [`PCPL_PKT_W-1:0] pkt_word;
	wire logic pay_done;
	wire logic [`PCPL_PAY_W-1:0] pay_word;
	assign pkt_word = shift_next;
	assign pay_done = pkt_done && (slot_reg == 2'h3) && !drop_reg;
	// First received packet is slot 3, so it lands in the top word
	assign pay_word = {gather_reg[95:0], pkt_word};

	// Issue side: walk held payload slot 0 up to slot 3
	wire logic [`PCPL_PKT_W-1:0] issue_word;
	wire logic buf_full;
	wire logic buf_push;
	wire logic buf_pop;
	wire logic last_slot;
	wire logic [3:0] issue_op;
	assign issue_word = hold_reg[issue_reg*`PCPL_PKT_W +: `PCPL_PKT_W];
	assign buf_full = buf_cnt_reg == 2'h2;
	assign buf_push = issuing_reg && !buf_full;
	assign buf_pop = exec_valid_reg && exec_ready_in;
	assign last_slot = issue_reg == 2'h3;
	assign issue_op = issue_word[`PCPL_CMD_OP_MSB:`PCPL_CMD_OP_LSB];

	// Write/read leaving slot 3 makes the very next payload data
	wire logic op_opens_data;
	wire logic data_now;
	assign op_opens_data = buf_push && last_slot && !hold_data_reg &&
		(issue_op == `PCPL_OP_WRITE || issue_op == `PCPL_OP_READ);
	assign data_now = data_mode_reg || data_pending_reg ||
		op_opens_data;

	// Look ahead one edge: stall before a payload would overwrite hold
	wire logic discard_now;
	wire logic [1:0] slot_after;
	wire logic [5:0] beat_after;
	wire logic issuing_after;
	wire logic [1:0] issue_after;
	wire logic [1:0] buf_fill_next;
	wire logic last_push_next;
	wire logic stall_next;
	assign discard_now = sel_edge && (beat_reg != 6'h00 || slot_reg != 2'h0);
	assign slot_after = discard_now ? 2'h0 :
		pkt_done ? slot_reg + 2'h1 : slot_reg;
	assign beat_after = discard_now ? 6'h00 :
		beat_fire ? beat_next : beat_reg;
	assign issuing_after = pay_done ? 1'b1 :
		(buf_push && last_slot) ? 1'b0 : issuing_reg;
	assign issue_after = pay_done ? 2'h0 :
		buf_push ? issue_reg + 2'h1 : issue_reg;
	assign buf_fill_next = buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
	// Last slot leaving at the same edge frees hold in time
	assign last_push_next = issue_after == 2'h3 && buf_fill_next != 2'h2;
	assign stall_next = issuing_after && !last_push_next &&
		slot_after == 2'h3 && beat_after == beats_per_pkt - 6'h01;

	// Sequencing: preamble, commands, then loaded; PCPL_ST_DATA is never entered
	always_comb begin
		state_next = state_reg;
		case (state_reg)
		pcpl_pkg::PCPL_ST_PREAMBLE:
			if (pay_done && pre_cnt_reg == `PCPL_PREAMBLE_PAYS - 3'h1)
				state_next = pcpl_pkg::PCPL_ST_CMD;
		pcpl_pkg::PCPL_ST_CMD:
			if (buf_push && last_slot && !hold_data_reg &&
				issue_op == `PCPL_OP_DONE)
				state_next = pcpl_pkg::PCPL_ST_LOADED;
		pcpl_pkg::PCPL_ST_DATA:
			state_next = pcpl_pkg::PCPL_ST_DATA;
		pcpl_pkg::PCPL_ST_LOADED:
			state_next = pcpl_pkg::PCPL_ST_LOADED;
		default: state_next = pcpl_pkg::PCPL_ST_PREAMBLE;
		endcase
	end

	// Receive: shift, count beats, gather payload, drop on select change
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			shift_reg <= 32'h00000000;
			beat_reg <= 6'h00;
			slot_reg <= 2'h0;
			gather_reg <= 128'h0;
			sel_prev_reg <= 1'b0;
			drop_reg <= 1'b0;
			discard_reg <= 1'b0;
		end else if (ce_in) begin
			sel_prev_reg <= sel_active;
			discard_reg <= 1'b0;
			if (sel_edge && (beat_reg != 6'h00 || slot_reg != 2'h0)) begin
				// Partial request abandoned: restart alignment
				beat_reg <= 6'h00;
				slot_reg <= 2'h0;
				drop_reg <= 1'b0;
				discard_reg <= 1'b1;
			end else if (beat_fire) begin
				shift_reg <= shift_next;
				beat_reg <= beat_next;
				if (pkt_done) begin
					slot_reg <= slot_reg + 2'h1;
					gather_reg <= pay_word;
				end
			end
		end
	end

	// Hold register, issue walk and data-mode tracking
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hold_reg <= 128'h0;
			hold_data_reg <= 1'b0;
			issuing_reg <= 1'b0;
			issue_reg <= 2'h0;
			data_mode_reg <= 1'b0;
			data_pending_reg <= 1'b0;
			pre_cnt_reg <= 3'h0;
			state_reg <= pcpl_pkg::PCPL_ST_PREAMBLE;
			payload_valid_reg <= 1'b0;
			stall_reg <= 1'b0;
		end else if (ce_in) begin
			state_reg <= state_next;
			payload_valid_reg <= 1'b0;
			if (pay_done && state_reg == pcpl_pkg::PCPL_ST_PREAMBLE)
				pre_cnt_reg <= pre_cnt_reg + 3'h1;
			if (pay_done) begin
				hold_reg <= pay_word;
				hold_data_reg <= data_now;
				issuing_reg <= 1'b1;
				issue_reg <= 2'h0;
				if (data_now)
					payload_valid_reg <= 1'b1;
			end else if (buf_push) begin
				issue_reg <= issue_reg + 2'h1;
				if (last_slot)
					issuing_reg <= 1'b0;
			end
			// Write/read in slot 3 opens the data phase next payload
			if (op_opens_data)
				data_pending_reg <= 1'b1;
			if (pay_done && data_now) begin
				data_mode_reg <= 1'b1;
				data_pending_reg <= 1'b0;
			end
			// Stall the port only while a payload is still issuing
			stall_reg <= stall_next;
		end
	end

	// Two-entry buffer; a consumer stall loses no word
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			buf_wp_reg <= 1'b0;
			buf_rp_reg <= 1'b0;
			buf_cnt_reg <= 2'h0;
			exec_valid_reg <= 1'b0;
		end else if (ce_in) begin
			if (buf_push)
				buf_wp_reg <= !buf_wp_reg;
			if (buf_pop)
				buf_rp_reg <= !buf_rp_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
			exec_valid_reg <= (buf_cnt_reg + {1'b0, buf_push}
				- {1'b0, buf_pop}) != 2'h0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (ce_in && buf_push) begin
			buf_mem[buf_wp_reg].word <= issue_word;
			buf_mem[buf_wp_reg].slot <= issue_reg;
			buf_mem[buf_wp_reg].is_data <= hold_data_reg;
		end
	end

	// Status flags; done and user, once set, cannot be changed by later no-ops; ready follows mem_cleared_in
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			done_reg <= 1'b0;
			user_reg <= 1'b0;
			config_ready_flag_out <= 1'b0;
		end else if (ce_in) begin
			config_ready_flag_out <= mem_cleared_in;
			if (state_reg == pcpl_pkg::PCPL_ST_LOADED)
				done_reg <= 1'b1;
			if (done_reg && user_entered_in)
				user_reg <= 1'b1;
		end
	end

	// Registered outputs
	assign exec_valid_out = exec_valid_reg;
	assign exec_out = buf_mem[buf_rp_reg];
	assign payload_valid_out = payload_valid_reg;
	assign payload_out = hold_reg;
	assign host_stall_out = stall_reg;
	assign discard_out = discard_reg;
	assign config_complete_flag_out = done_reg;
	assign user_mode_flag_out = user_reg;

endmodule : pcpl_loader

// File: rtl/pcpl_defs.svh
/*
 * Constants for the parallel configuration port loader: bus widths,
 * mode encodings, preamble layout and timing counts.
 * Assumes inclusion from the package and the loader module only.
 */
`ifndef PCPL_DEFS_SVH
`define PCPL_DEFS_SVH

`define PCPL_BUS_W 32
`define PCPL_PKT_W 32
`define PCPL_PAY_W 128
`define PCPL_PKTS_PER_PAY 4
// Width mode codes on the width strap
`define PCPL_MODE_X1 2'h0
`define PCPL_MODE_X8 2'h1
`define PCPL_MODE_X16 2'h2
`define PCPL_MODE_X32 2'h3
// Beats per 32-bit packet for each mode
`define PCPL_BEATS_X1 6'h20
`define PCPL_BEATS_X8 6'h04
`define PCPL_BEATS_X16 6'h02
`define PCPL_BEATS_X32 6'h01
// Command encodings seen in the executed packet stream
`define PCPL_CMD_NOP 32'h00000000
`define PCPL_CMD_OP_MSB 31
`define PCPL_CMD_OP_LSB 28
`define PCPL_OP_WRITE 4'h1
`define PCPL_OP_READ 4'h2
`define PCPL_OP_DONE 4'hF
// Preamble is 512 bits: four payloads
`define PCPL_PREAMBLE_PAYS 3'h4
// Host wait after ready; host-side only, kept for reference
`define PCPL_READY_WAIT_CYC 5

`endif

// File: rtl/pcpl_pkg.sv
/*
 * Types for the parallel configuration port loader.
 * Assumes pcpl_defs.svh is on the include path.
 */
`include "pcpl_defs.svh"

package pcpl_pkg;

	// One payload, slot 0 is executed first
	typedef struct packed {
		logic [`PCPL_PKT_W-1:0] slot3;
		logic [`PCPL_PKT_W-1:0] slot2;
		logic [`PCPL_PKT_W-1:0] slot1;
		logic [`PCPL_PKT_W-1:0] slot0;
	} pcpl_payload_t;

	// Executed packet leaving the block
	typedef struct packed {
		logic is_data;
		logic [1:0] slot;
		logic [`PCPL_PKT_W-1:0] word;
	} pcpl_exec_t;

	typedef enum logic [3:0] {
		PCPL_ST_PREAMBLE = 4'h1,
		PCPL_ST_CMD = 4'h2,
		PCPL_ST_DATA = 4'h4,
		PCPL_ST_LOADED = 4'h8
	} pcpl_state_t;

endpackage : pcpl_pkg

// File: dv/pcpl_loader_monitor.sv
/*
 * Port checker for the configuration port loader.
 * Assumes it is bound to pcpl_loader and sees its ports by name.
 */
module pcpl_loader_monitor (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic mem_cleared_in,
	input wire logic host_port_select_n_in,
	input wire logic exec_ready_in,
	input wire logic exec_valid_out,
	input wire pcpl_pkg::pcpl_exec_t exec_out,
	input wire logic payload_valid_out,
	input wire logic discard_out,
	input wire logic config_ready_flag_out,
	input wire logic config_complete_flag_out,
	input wire logic user_mode_flag_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// A stalled head must not move, or a word is lost
	sequence s_head_held;
		exec_valid_out && $stable(exec_out);
	endsequence
	sequence s_slot_taken;
		exec_valid_out && exec_ready_in && !exec_out.is_data &&
			exec_out.slot != 2'h3;
	endsequence
	a_head_held: assert property (exec_valid_out && !exec_ready_in |=>
		s_head_held) else $error("exec head moved while stalled");
	a_slot_step: assert property (s_slot_taken |=> !exec_valid_out ||
		exec_out.slot == $past(exec_out.slot) + 2'h1)
		else $error("slot order broken");
	a_ready_tracks: assert property (ce_in |=>
		config_ready_flag_out == $past(mem_cleared_in))
		else $error("ready flag not tracking clear");
	a_done_sticky: assert property (config_complete_flag_out |=>
		config_complete_flag_out) else $error("done flag dropped");
	a_user_sticky: assert property (user_mode_flag_out |=>
		user_mode_flag_out) else $error("user flag dropped");
	a_pay_pulse: assert property (payload_valid_out |=>
		!payload_valid_out) else $error("payload pulse too long");
	a_discard_pulse: assert property (discard_out |=> !discard_out)
		else $error("discard pulse too long");
	a_idle_quiet: assert property (host_port_select_n_in [*4] |->
		!discard_out) else $error("discard while idle");
	a_reset_quiet: assert property (disable iff (1'b0) !nrst_in |->
		!exec_valid_out && !config_complete_flag_out &&
		!user_mode_flag_out) else $error("outputs set in reset");
endmodule : pcpl_loader_monitor

bind pcpl_loader pcpl_loader_monitor u_mon (.*);

// File: dv/pcpl_host_model.sv
/*
 * Host model: streams packets MSB first at the selected width.
 * Assumes beats are taken at a rising edge while stall is low.
 */
module pcpl_host_model (
	input wire logic clk_in,
	input wire logic stall_in,
	input wire logic [1:0] mode_in,
	output logic sel_n_out,
	output logic [31:0] bus_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sel_n_out = 1'b1;
		bus_out = 32'h0;
	end
	// One packet, earliest beat is the top; beat held while stalled
	task automatic send_pkt(input logic [31:0] w);
		int bw;
		bw = (mode_in == 2'h0) ? 1 : 8 << (mode_in - 2'h1);
		for (int i = 0; i < 32 / bw; i++) begin
			sel_n_out <= 1'b0;
			bus_out <= (w >> (32 - bw * (i + 1))) & ((33'h1 << bw) - 1);
			@(posedge clk_in);
			while (stall_in) @(posedge clk_in);
		end
	endtask : send_pkt
	// Slot 3 goes first; n below 4 cuts the request short
	task automatic send_pay(input logic [127:0] p, input int n);
		for (int i = 0; i < n; i++) send_pkt(p[127 - 32 * i -: 32]);
	endtask : send_pay
	// Released bus shows the inverse, not the last value
	task automatic release_bus();
		sel_n_out <= 1'b1;
		bus_out <= ~bus_out;
		@(posedge clk_in);
	endtask : release_bus
endmodule : pcpl_host_model

// File: dv/tb.sv
/*
 * Testbench for the loader: width modes, ordering, data, discard, done.
 * Assumes the host model and checker are compiled alongside.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] SYNC = 32'h3A5C_0001; // Arbitrary value
	localparam logic [31:0] DEVID = 32'h4123_4567; // Arbitrary value
	localparam logic [31:0] INST = 32'h5000_0007; // Arbitrary value
	logic mclk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [1:0] mode = 2'h3;
	logic cleared = 1'b0;
	logic rdy = 1'b1;
	logic user = 1'b0;
	logic sel_n, stall, ev, pv, disc, fr, fc, fu;
	logic [31:0] bus;
	pcpl_pkg::pcpl_exec_t eo;
	pcpl_pkg::pcpl_payload_t po;
	pcpl_pkg::pcpl_exec_t got[$];
	logic [127:0] pays[$];
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	logic saw_disc, saw_stall;
	always #50 mclk_in = ~mclk_in;
	pcpl_host_model host (.clk_in(mclk_in), .stall_in(stall),
		.mode_in(mode), .sel_n_out(sel_n), .bus_out(bus));
	pcpl_loader uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
		.width_mode_in(mode), .mem_cleared_in(cleared),
		.host_port_select_n_in(sel_n), .host_config_data_bus_in(bus),
		.exec_ready_in(rdy), .user_entered_in(user),
		.exec_valid_out(ev), .exec_out(eo), .payload_valid_out(pv),
		.payload_out(po), .host_stall_out(stall), .discard_out(disc),
		.config_ready_flag_out(fr), .config_complete_flag_out(fc),
		.user_mode_flag_out(fu));
	// Capture handshakes; also the hang limit
	always @(posedge mclk_in) begin
		cyc++;
		if (ev && rdy) got.push_back(eo);
		if (pv) pays.push_back(po);
		if (disc) saw_disc = 1'b1;
		if (stall) saw_stall = 1'b1;
		if (cyc == 40000) begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: %h vs %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : tick
	// Wait, bounded, until n words have executed
	task automatic wait_got(input int n);
		for (int k = 0; k < 600 && got.size() < n; k++) tick(1);
	endtask : wait_got
	// Reset with clear low, then clear, check ready after two clocks, and wait five more
	task automatic start(input logic [1:0] m);
		nrst_in <= 1'b0;
		cleared <= 1'b0;
		mode <= m;
		tick(10);
		nrst_in <= 1'b1;
		tick(2);
		got.delete();
		pays.delete();
		saw_disc = 1'b0;
		chk(fr, 1'b0);
		cleared <= 1'b1;
		tick(2);
		chk(fr, 1'b1);
		tick(5);
	endtask : start
	task automatic preamble();
		host.send_pay({32'h0, INST, DEVID, SYNC}, 4);
		for (int i = 0; i < 3; i++) host.send_pay(128'h0, 4);
	endtask : preamble
	task automatic t_order(input logic [1:0] m);
		start(m);
		host.send_pay({32'h0, INST, DEVID, SYNC}, 4);
		host.release_bus();
		wait_got(4);
		chk(got.size(), 4);
		for (int i = 0; i < 4 && i < got.size(); i++)
			chk(got[i], {1'b0, 2'(i), i == 0 ? SYNC : i == 1 ? DEVID :
				i == 2 ? INST : 32'h0});
	endtask : t_order
	// Consumer stalls at first, so the buffer fills and holds the host
	task automatic t_write();
		start(2'h3);
		rdy <= 1'b0;
		saw_stall = 1'b0;
		fork
			begin
				tick(30);
				rdy <= 1'b1;
			end
		join_none
		preamble();
		host.send_pay({32'h1000_0000, 96'h0}, 4);
		host.send_pay(128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, 4);
		host.release_bus();
		tick(20);
		chk(saw_stall, 1'b1);
		chk(pays.size(), 1);
		if (pays.size() > 0)
			chk(pays[0], 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210);
		wait_got(20);
		if (got.size() >= 20) chk(got[19], {1'b0, 2'h3, 32'h1000_0000});
		wait_got(24);
		chk(got.size(), 24);
		if (got.size() >= 21) chk(got[20], {1'b1, 2'h0, 32'h7654_3210});
	endtask : t_write
	task automatic t_discard();
		start(2'h3);
		preamble();
		host.send_pay({4{32'h0}}, 2);
		host.release_bus();
		tick(6);
		chk(saw_disc, 1'b1);
		host.send_pay({4{32'h0}}, 4);
		host.release_bus();
		wait_got(20);
		chk(got.size(), 20);
	endtask : t_discard
	task automatic t_done();
		start(2'h1);
		preamble();
		host.send_pay({32'hF000_0000, 96'h0}, 4);
		tick(10);
		chk(fc, 1'b1);
		user <= 1'b1;
		tick(4);
		chk(fu, 1'b1);
		host.send_pay(128'h0, 4);
		host.release_bus();
		tick(10);
		chk({fc, fu}, 2'h3);
	endtask : t_done
	task automatic complete_run();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	initial begin
		for (int m = 0; m < 4; m++) t_order(2'(m));
		t_write();
		t_discard();
		t_done();
		complete_run();
	end
endmodule : tb
